// ==== include/line_raster_cfg.svh ====
// constants and register map of the line stipple and wide line rasterizer
`ifndef LINE_RASTER_CFG_SVH
`define LINE_RASTER_CFG_SVH

// register byte addresses
`define REG_CTRL        8'h00
`define REG_PATTERN     8'h04
`define REG_WIDTH       8'h08
`define REG_STATUS      8'h0C
`define REG_AA_RANGE    8'h10

// control fields
`define CTRL_STIPPLE_BIT   0
`define CTRL_SMOOTH_BIT    1
`define CTRL_MSAA_BIT      2
`define CTRL_CBUF_LSB      4
`define CTRL_CBUF_MSB      5

// dash pattern register fields
`define PAT_MSB         15
`define FACTOR_LSB      16
`define FACTOR_MSB      31

// width is unsigned fixed point with four fraction bits
`define WIDTH_FRAC      4
`define WIDTH_HALF      12'h008
`define WIDTH_BITS      12

// reset values
`define RST_PATTERN     16'hFFFF
`define RST_FACTOR      9'h001
`define RST_WIDTH       12'h010
`define RST_CTRL        6'h00

// repeat factor limits and pattern length
`define FACTOR_MIN      9'h001
`define FACTOR_MAX      9'h100
`define PAT_LEN         5'h10
`define CNT_BITS        12

// coverage scale and sample layout
`define COV_FULL        8'hFF
`define COV_SCALE       8
`define SAMPLE_COUNT    4
`define ONE_BUFFER      2'h1

`endif

// ==== include/line_raster_pkg.sv ====
// types shared by the line stipple and wide line rasterizer
`default_nettype none
package line_raster_pkg;

	// one segment from primitive assembly
	typedef struct packed {
		logic        new_prim;
		logic        independent;
		logic        clipped;
		logic [11:0] x0;
		logic [11:0] y0;
		logic [11:0] x1;
		logic [11:0] y1;
		logic [15:0] z0;
		logic [15:0] z1;
	} seg_type;

	// one surviving fragment for per-fragment processing
	typedef struct packed {
		logic [11:0] x;
		logic [11:0] y;
		logic [15:0] z;
		logic [16:0] z_step;
		logic [7:0]  coverage;
		logic [3:0]  samples;
	} frag_type;

	// register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        write;
		logic        read;
	} reg_req_type;

	typedef enum logic {ST_IDLE, ST_RUN} walk_state_type;

endpackage
`default_nettype wire

// ==== verilog/line_raster_stipple_wide.sv ====
// line rasterizer back end: dash pattern, wide runs, smoothing and multisample coverage
`include "line_raster_cfg.svh"
`default_nettype none
module line_raster_stipple_wide #(
	parameter int MAX_ALIASED_WIDTH = 8,
	parameter int MAX_SMOOTH_WIDTH  = 8
) (
	input  wire logic                         i_clock,
	input  wire logic                         i_rst,
	input  wire line_raster_pkg::reg_req_type i_reg,
	output logic [31:0]                       o_reg_rdata,
	input  wire line_raster_pkg::seg_type     i_seg,
	input  wire logic                         i_seg_valid,
	output logic                              o_seg_ready,
	output line_raster_pkg::frag_type         o_frag,
	output logic                              o_frag_valid,
	input  wire logic                         i_frag_ready
);
	import line_raster_pkg::*;

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	// aliased maximum must cover one and the smoothed maximum; the run adds an edge pixel
	if (MAX_ALIASED_WIDTH < 1 || MAX_ALIASED_WIDTH > 254)
		$error("aliased width out of range");
	if (MAX_SMOOTH_WIDTH < 1 || MAX_SMOOTH_WIDTH > MAX_ALIASED_WIDTH)
		$error("smoothed width above aliased width");

	localparam logic [7:0] MAX_AW = 8'(MAX_ALIASED_WIDTH);
	localparam logic [7:0] MAX_SW = 8'(MAX_SMOOTH_WIDTH);

	// ------------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------------
	// pattern bit picked by the running counter
	function automatic logic pattern_bit(input logic [15:0] pat, input logic [8:0] fac,
		input logic [`CNT_BITS-1:0] cnt);
		logic [`CNT_BITS-1:0] q;
		q = cnt / `CNT_BITS'(fac);
		return pat[q[3:0]];
	endfunction

	// linear screen-space depth at step i of n
	function automatic logic [15:0] depth_at(input logic [15:0] za, input logic [15:0] zb,
		input logic [11:0] i, input logic [11:0] n);
		logic signed [17:0] dz;
		logic signed [30:0] prod;
		logic signed [30:0] q;
		dz   = 18'(signed'({2'b00, zb})) - 18'(signed'({2'b00, za}));
		prod = 31'(dz) * 31'(signed'({1'b0, i}));
		q    = prod / 31'(signed'({1'b0, n}));
		return 16'(31'(signed'({1'b0, za})) + q);
	endfunction

	// absolute difference of two coordinates
	function automatic logic [11:0] abs_diff(input logic [11:0] a, input logic [11:0] b);
		return (a >= b) ? (a - b) : (b - a);
	endfunction

	// ------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------
	logic [15:0]             pattern_reg;
	logic [8:0]              factor_reg;
	logic [`WIDTH_BITS-1:0]  width_reg;
	logic [5:0]              ctrl_reg;
	logic signed [15:0]      fac_in;
	logic [8:0]              fac_sat;

	// signed factor saturated before storing
	assign fac_in  = signed'(i_reg.wdata[`FACTOR_MSB:`FACTOR_LSB]);
	assign fac_sat = (fac_in < 16'sd1) ? `FACTOR_MIN :
	                 (fac_in > 16'sd256) ? `FACTOR_MAX : 9'(fac_in);

	// dash pattern and repeat factor written together
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			pattern_reg <= `RST_PATTERN;
			factor_reg  <= `RST_FACTOR;
		end
		else if (i_reg.write && i_reg.addr == `REG_PATTERN)
		begin
			pattern_reg <= i_reg.wdata[`PAT_MSB:0];
			factor_reg  <= fac_sat;
		end
	end

	// width; a zero width is an error upstream and is ignored here
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			width_reg <= `RST_WIDTH;
		else if (i_reg.write && i_reg.addr == `REG_WIDTH && i_reg.wdata[11:0] != 12'h000)
			width_reg <= i_reg.wdata[`WIDTH_BITS-1:0];
	end

	// enables: masking, edge_smoothing_enable, multisample, coverage_buffer_count
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			ctrl_reg <= `RST_CTRL;
		else if (i_reg.write && i_reg.addr == `REG_CTRL)
			ctrl_reg <= i_reg.wdata[`CTRL_CBUF_MSB:0];
	end

	logic       stipple_enable;
	logic       edge_smoothing_enable;
	logic       ms_active;
	logic [1:0] coverage_buffer_count;
	logic [15:0] eff_pattern;
	assign stipple_enable        = ctrl_reg[`CTRL_STIPPLE_BIT];
	assign edge_smoothing_enable = ctrl_reg[`CTRL_SMOOTH_BIT];
	assign coverage_buffer_count = ctrl_reg[`CTRL_CBUF_MSB:`CTRL_CBUF_LSB];
	assign ms_active = ctrl_reg[`CTRL_MSAA_BIT] && coverage_buffer_count == `ONE_BUFFER;
	assign eff_pattern = stipple_enable ? pattern_reg : `RST_PATTERN;

	// ------------------------------------------------------------------
	// width rounding
	// ------------------------------------------------------------------
	logic [8:0] width_round;
	logic [7:0] width_alias;
	logic [7:0] width_smooth;
	logic [7:0] width_eff;
	// spare top bit keeps the widest settings from wrapping to a thin line
	assign width_round  = 9'(({1'b0, width_reg} + 13'(`WIDTH_HALF)) >> `WIDTH_FRAC);
	assign width_alias  = (width_round == 9'h000) ? 8'h01 :
	                      (width_round > {1'b0, MAX_AW}) ? MAX_AW : width_round[7:0];
	// smoothed widths outside the readable range fall back to the nearest supported
	assign width_smooth = (width_alias > MAX_SW) ? MAX_SW : width_alias;
	assign width_eff    = (edge_smoothing_enable || ms_active) ? width_smooth : width_alias;

	// ------------------------------------------------------------------
	// segment walker
	// ------------------------------------------------------------------
	walk_state_type       state_reg;
	seg_type              seg_reg;
	logic                 x_major_reg;
	logic [11:0]          dmaj_reg;
	logic [11:0]          dmin_reg;
	logic                 smaj_reg;
	logic                 smin_reg;
	logic [11:0]          step_reg;
	logic [11:0]          maj_reg;
	logic [11:0]          min_reg;
	logic signed [14:0]   err_reg;
	logic [7:0]           run_reg;
	logic [7:0]           run_len_reg;
	logic [`CNT_BITS-1:0] cnt_reg;
	logic                 smooth_reg;
	logic                 ms_reg;

	logic [11:0] adx;
	logic [11:0] ady;
	logic        seg_x_major;
	logic        accept;
	assign adx         = abs_diff(i_seg.x1, i_seg.x0);
	assign ady         = abs_diff(i_seg.y1, i_seg.y0);
	assign seg_x_major = adx >= ady;
	assign o_seg_ready = state_reg == ST_IDLE;
	assign accept      = i_seg_valid && o_seg_ready;

	// current column data
	logic        col_keep;
	logic        last_in_run;
	logic        last_step;
	logic        can_emit;
	logic        advance;
	assign col_keep    = pattern_bit(eff_pattern, factor_reg, cnt_reg);
	assign last_in_run = !col_keep || run_reg == run_len_reg - 8'h01;
	assign last_step   = step_reg == dmaj_reg - 12'h001;
	assign can_emit    = !o_frag_valid || i_frag_ready;
	assign advance     = state_reg == ST_RUN && can_emit;

	// walk control: one fragment of a run per cycle, a dropped run in one cycle
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			state_reg <= ST_IDLE;
		else if (accept && (seg_x_major ? adx : ady) != 12'h000)
			state_reg <= ST_RUN; // half-open, zero length emits nothing
		else if (advance && last_in_run && last_step)
			state_reg <= ST_IDLE;
	end

	// segment setup; minor start shifted by (w-1)/2
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			seg_reg     <= '0;
			x_major_reg <= 1'b1;
			dmaj_reg    <= 12'h000;
			dmin_reg    <= 12'h000;
			smaj_reg    <= 1'b0;
			smin_reg    <= 1'b0;
			run_len_reg <= 8'h01;
			smooth_reg  <= 1'b0;
			ms_reg      <= 1'b0;
		end
		else if (accept)
		begin
			seg_reg     <= i_seg;
			x_major_reg <= seg_x_major;
			dmaj_reg    <= seg_x_major ? adx : ady;
			dmin_reg    <= seg_x_major ? ady : adx;
			smaj_reg    <= seg_x_major ? (i_seg.x1 < i_seg.x0) : (i_seg.y1 < i_seg.y0);
			smin_reg    <= seg_x_major ? (i_seg.y1 < i_seg.y0) : (i_seg.x1 < i_seg.x0);
			// smoothed and multisample runs take one extra edge pixel
			run_len_reg <= (edge_smoothing_enable || ms_active) ? width_eff + 8'h01 : width_eff;
			smooth_reg  <= edge_smoothing_enable;
			ms_reg      <= ms_active;
		end
	end

	// major and minor positions with bresenham error, start to end
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			step_reg <= 12'h000;
			maj_reg  <= 12'h000;
			min_reg  <= 12'h000;
			err_reg  <= '0;
		end
		else if (accept)
		begin
			step_reg <= 12'h000;
			maj_reg  <= seg_x_major ? i_seg.x0 : i_seg.y0;
			min_reg  <= (seg_x_major ? i_seg.y0 : i_seg.x0) - 12'((width_eff - 8'h01) >> 1);
			err_reg  <= 15'(signed'({3'b000, seg_x_major ? ady : adx}) <<< 1)
			          - 15'(signed'({3'b000, seg_x_major ? adx : ady}));
		end
		else if (advance && last_in_run)
		begin
			step_reg <= step_reg + 12'h001;
			maj_reg  <= smaj_reg ? maj_reg - 12'h001 : maj_reg + 12'h001;
			if (err_reg > 0)
			begin
				min_reg <= smin_reg ? min_reg - 12'h001 : min_reg + 12'h001;
				err_reg <= err_reg + 15'(signed'({3'b000, dmin_reg}) <<< 1)
				         - 15'(signed'({3'b000, dmaj_reg}) <<< 1);
			end
			else
				err_reg <= err_reg + 15'(signed'({3'b000, dmin_reg}) <<< 1);
		end
	end

	// position inside the replicated run
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			run_reg <= 8'h00;
		else if (accept || (advance && last_in_run))
			run_reg <= 8'h00;
		else if (advance)
			run_reg <= run_reg + 8'h01;
	end

	// wrap after sixteen repeats so a factor that is no power of two keeps its bit
	logic [12:0] cnt_last;
	assign cnt_last = {factor_reg, 4'h0} - 13'h0001;

	// counter steps once per column; a joined segment keeps whatever it holds
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			cnt_reg <= '0;
		else if (accept && (i_seg.new_prim || i_seg.independent))
			cnt_reg <= '0;
		else if (accept)
			cnt_reg <= cnt_reg;
		else if (advance && last_in_run && cnt_reg == cnt_last[`CNT_BITS-1:0])
			cnt_reg <= '0;
		else if (advance && last_in_run)
			cnt_reg <= cnt_reg + `CNT_BITS'(1);
	end

	// ------------------------------------------------------------------
	// coverage
	// ------------------------------------------------------------------
	// fraction of the line centre above the base pixel, in 1/256
	logic [7:0]  frac;
	logic [21:0] frac_q;
	logic [21:0] frac_num;
	logic [12:0] frac_den;
	logic        run_low;
	logic        run_high;
	logic [7:0]  cov;
	logic [3:0]  samples;
	assign frac_num = 22'(unsigned'(err_reg + 15'(signed'({3'b000, dmaj_reg})))) << `COV_SCALE;
	assign frac_den = {dmaj_reg, 1'b0};
	assign frac_q   = (frac_den == 13'h0000) ? 22'h000000 : frac_num / 22'(frac_den);
	// a centre on the pixel top gives 256, held at full scale instead of wrapping
	assign frac     = (frac_q > 22'(`COV_FULL)) ? `COV_FULL : frac_q[7:0];
	assign run_low  = run_reg == 8'h00;
	assign run_high = run_reg == run_len_reg - 8'h01;

	// edge pixels of the rectangle split coverage by the centre fraction
	always_comb
	begin
		cov     = `COV_FULL;
		samples = '1;
		if (smooth_reg || ms_reg)
		begin
			if (run_low)
				cov = `COV_FULL - frac;
			else if (run_high)
				cov = frac;
			for (int k = 0; k < `SAMPLE_COUNT; k++)
			begin
				// sample k sits at (2k+1)/8 across the pixel
				if (run_low)
					samples[k] = 8'(((2 * k) + 1) * 32) >= frac;
				else if (run_high)
					samples[k] = 8'(((2 * k) + 1) * 32) < frac;
			end
		end
	end

	// multisample drops pixels with no sample inside; smoothing drops empty ones
	logic emit_ok;
	assign emit_ok = col_keep && (ms_reg ? samples != 4'h0 : cov != 8'h00);

	// ------------------------------------------------------------------
	// fragment output
	// ------------------------------------------------------------------
	logic [11:0] minor_pos;
	logic [16:0] zstep;
	assign minor_pos = min_reg + 12'(run_reg);
	assign zstep = 17'(depth_at(seg_reg.z0, seg_reg.z1, 12'h001, dmaj_reg))
	             - 17'(seg_reg.z0);

	// registered fragment held until taken
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_frag       <= '0;
			o_frag_valid <= 1'b0;
		end
		else if (can_emit)
		begin
			o_frag_valid <= advance && emit_ok;
			if (advance && emit_ok)
			begin
				o_frag.x        <= x_major_reg ? maj_reg : minor_pos;
				o_frag.y        <= x_major_reg ? minor_pos : maj_reg;
				o_frag.z        <= depth_at(seg_reg.z0, seg_reg.z1, step_reg, dmaj_reg);
				o_frag.z_step   <= zstep;
				o_frag.coverage <= ms_reg ? `COV_FULL : cov;
				o_frag.samples  <= samples;
			end
		end
	end

	// ------------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------------
	// data stands only in the cycle after the read strobe
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			o_reg_rdata <= 32'h0000_0000;
		else if (!i_reg.read)
			o_reg_rdata <= 32'h0000_0000;
		else
		begin
			unique case (i_reg.addr)
				`REG_CTRL:     o_reg_rdata <= 32'(ctrl_reg);
				`REG_PATTERN:  o_reg_rdata <= {7'h00, factor_reg, pattern_reg};
				`REG_WIDTH:    o_reg_rdata <= 32'(width_reg);
				`REG_STATUS:   o_reg_rdata <= {15'h0000, state_reg == ST_RUN, 4'h0, cnt_reg};
				`REG_AA_RANGE: o_reg_rdata <= {16'h0000, MAX_AW, MAX_SW};
				default:       o_reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== sim/frag_sink_model.sv ====
// downstream fragment consumer model with an optional stall pattern
`default_nettype none
module frag_sink_model
(
	input  wire logic i_clock,
	input  wire logic i_rst,
	input  wire logic i_stall,
	output logic      o_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	logic toggle_reg;

	// ----------------------------------------------------------------
	// stall generator
	// ----------------------------------------------------------------
	// half-rate acceptance keeps the output register waiting every other cycle
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			toggle_reg <= 1'b0;
		else
			toggle_reg <= ~toggle_reg;
	end

	assign o_ready = i_stall ? toggle_reg : 1'b1;
endmodule
`default_nettype wire

// ==== sim/line_raster_monitor.sv ====
// port checker for the line stipple and wide line rasterizer
`include "line_raster_cfg.svh"
`default_nettype none
module line_raster_monitor
(
	input wire logic                         i_clock,
	input wire logic                         i_rst,
	input wire line_raster_pkg::reg_req_type i_reg,
	input wire logic [31:0]                  o_reg_rdata,
	input wire line_raster_pkg::seg_type     i_seg,
	input wire logic                         i_seg_valid,
	input wire logic                         o_seg_ready,
	input wire line_raster_pkg::frag_type    o_frag,
	input wire logic                         o_frag_valid,
	input wire logic                         i_frag_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	import line_raster_pkg::*;

	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	sequence pat_write_read;
		(i_reg.write && i_reg.addr == `REG_PATTERN) ##1 (i_reg.read && i_reg.addr == `REG_PATTERN);
	endsequence

	rdata_idle_a: assert property (!$past(i_reg.read) |-> o_reg_rdata == 32'h0)
		else $error("read data not zero outside answer cycle");
	pattern_low_a: assert property (pat_write_read |=> o_reg_rdata[15:0] == $past(i_reg.wdata[15:0], 2))
		else $error("pattern readback differs");
	factor_high_a: assert property ((i_reg.write && i_reg.addr == `REG_PATTERN && $signed(i_reg.wdata[31:16]) > 256)
		##1 (i_reg.read && i_reg.addr == `REG_PATTERN) |=> o_reg_rdata[31:16] == 16'h0100)
		else $error("factor not saturated at top");
	factor_low_a: assert property ((i_reg.write && i_reg.addr == `REG_PATTERN && $signed(i_reg.wdata[31:16]) < 1)
		##1 (i_reg.read && i_reg.addr == `REG_PATTERN) |=> o_reg_rdata[31:16] == 16'h0001)
		else $error("factor not saturated at bottom");
	width_zero_a: assert property ((i_reg.write && i_reg.addr == `REG_WIDTH && i_reg.wdata[11:0] == 12'h000)
		##1 (i_reg.read && i_reg.addr == `REG_WIDTH) |=> o_reg_rdata[11:0] != 12'h000)
		else $error("zero width was stored");
	unmapped_read_a: assert property (i_reg.read && !(i_reg.addr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})
		|=> o_reg_rdata == 32'h0)
		else $error("unmapped read not zero");

	// ----------------------------------------------------------------
	// segment and fragment streams
	// ----------------------------------------------------------------
	accept_busy_a: assert property (i_seg_valid && o_seg_ready && i_seg.x0 != i_seg.x1 |=> !o_seg_ready)
		else $error("walker idle after accepting a segment");
	frag_hold_a: assert property (o_frag_valid && !i_frag_ready |=> o_frag_valid && $stable(o_frag))
		else $error("fragment dropped while stalled");
	frag_source_a: assert property ($rose(o_frag_valid) |-> !$past(o_seg_ready))
		else $error("fragment without a segment walk");

	accept_c: cover property (i_seg_valid && o_seg_ready);
	stall_c: cover property (o_frag_valid && !i_frag_ready);
	readback_c: cover property (pat_write_read);
endmodule

bind line_raster_stipple_wide line_raster_monitor monitor_u (.i_clock(i_clock), .i_rst(i_rst),
	.i_reg(i_reg), .o_reg_rdata(o_reg_rdata), .i_seg(i_seg), .i_seg_valid(i_seg_valid),
	.o_seg_ready(o_seg_ready), .o_frag(o_frag), .o_frag_valid(o_frag_valid),
	.i_frag_ready(i_frag_ready));
`default_nettype wire

// ==== sim/line_raster_stipple_wide_bench.sv ====
// self-checking bench for the line stipple and wide line rasterizer
`include "line_raster_cfg.svh"
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module line_raster_stipple_wide_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import line_raster_pkg::*;

	localparam int MAX_W = 8;

	logic        i_clock = 1'b0;
	logic        i_rst = 1'b1;
	reg_req_type i_reg = '0;
	logic [31:0] o_reg_rdata;
	seg_type     i_seg = '0;
	logic        i_seg_valid = 1'b0;
	logic        o_seg_ready;
	frag_type    o_frag;
	logic        o_frag_valid;
	logic        frag_ready;
	logic        stall = 1'b0;
	int          num_errors = 0;
	int          compares = 0;
	logic [35:0] got_q[$];
	logic [35:0] exp_q[$];

	always #12.5 i_clock = ~i_clock;

	line_raster_stipple_wide #(.MAX_ALIASED_WIDTH(MAX_W), .MAX_SMOOTH_WIDTH(MAX_W)) dut_u (
		.i_clock(i_clock), .i_rst(i_rst), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
		.i_seg(i_seg), .i_seg_valid(i_seg_valid), .o_seg_ready(o_seg_ready),
		.o_frag(o_frag), .o_frag_valid(o_frag_valid), .i_frag_ready(frag_ready));

	frag_sink_model sink_u (.i_clock(i_clock), .i_rst(i_rst), .i_stall(stall), .o_ready(frag_ready));

	// ----------------------------------------------------------------
	// collection and bus tasks
	// ----------------------------------------------------------------
	// record every fragment handed over, in arrival order
	always @(posedge i_clock)
	begin
		if (o_frag_valid === 1'b1 && frag_ready === 1'b1)
			got_q.push_back({o_frag.x, o_frag.y, o_frag.coverage, o_frag.samples});
	end

	// write strobe stays up until the next task's edge takes it
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_reg <= '{a, d, 1'b1, 1'b0};
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clock);
		i_reg <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge i_clock);
		i_reg <= '0;
		#1 d = o_reg_rdata;
	endtask

	// offer one segment, then wait until the walk and the output drain
	task automatic run_seg(input logic [11:0] x0, y0, x1, y1, input logic np, ind);
		int n;
		@(posedge i_clock);
		i_reg <= '0;
		i_seg <= '{np, ind, 1'b0, x0, y0, x1, y1, 16'h0000, 16'h0000};
		i_seg_valid <= 1'b1;
		@(posedge i_clock);
		i_seg_valid <= 1'b0;
		for (n = 0; n < 200; n++)
		begin
			@(posedge i_clock);
			#1;
			if (o_seg_ready === 1'b1 && o_frag_valid === 1'b0)
				break;
		end
		`CHK(o_seg_ready, 1'b1)
		`CHK(o_frag_valid, 1'b0)
	endtask

	// expected x-major columns: runs of w from y-(w-1)/2 upward, kept by the pattern
	task automatic expect_run(input int x0, n, y, w, mask, input logic [15:0] pat, input int fac, c0);
		for (int c = 0; c < n; c++)
			if (mask == 0 || pat[((c0 + c) / fac) % 16] === 1'b1)
				for (int k = 0; k < w; k++)
					exp_q.push_back({12'(x0 + c), 12'(y - (w - 1) / 2 + k), `COV_FULL, 4'hF});
	endtask

	task automatic check_frags;
		`CHK(32'(got_q.size()), 32'(exp_q.size()))
		for (int i = 0; i < exp_q.size() && i < got_q.size(); i++)
			`CHK(got_q[i], exp_q[i])
		got_q.delete();
		exp_q.delete();
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_reset;
		logic [31:0] d;
		reg_read(`REG_CTRL, d);
		`CHK(d[5:0], 6'h00)
		reg_read(`REG_PATTERN, d);
		`CHK(d, 32'h0001_FFFF)
		reg_read(`REG_WIDTH, d);
		`CHK(d[11:0], 12'h010)
		reg_read(`REG_AA_RANGE, d);
		`CHK(d, {16'h0000, 8'(MAX_W), 8'(MAX_W)})
	endtask

	task automatic test_pattern;
		logic [31:0] wr[5] = '{32'h0003_ABCD, 32'h0200_1234, 32'hFFFF_0F0F, 32'h0000_8001, 32'h0100_FFFF};
		logic [31:0] ex[5] = '{32'h0003_ABCD, 32'h0100_1234, 32'h0001_0F0F, 32'h0001_8001, 32'h0100_FFFF};
		logic [31:0] d;
		for (int i = 0; i < 5; i++)
		begin
			reg_write(`REG_PATTERN, wr[i]);
			reg_read(`REG_PATTERN, d);
			`CHK(d, ex[i])
		end
		reg_write(`REG_WIDTH, 32'h0000_F000);
		reg_read(`REG_WIDTH, d);
		`CHK(d[11:0], 12'h010)
		reg_write(8'h20, 32'hFFFF_FFFF);
		reg_read(8'h20, d);
		`CHK(d, 32'h0)
		reg_read(`REG_CTRL, d);
		`CHK(d[5:0], 6'h00)
	endtask

	// stalled stream; counter carries into a joined segment and clears for an independent one
	task automatic test_stipple;
		logic [31:0] d;
		stall = 1'b1;
		reg_write(`REG_CTRL, 32'h1);
		reg_write(`REG_PATTERN, 32'h0002_0005);
		run_seg(12'd0, 12'd0, 12'd8, 12'd0, 1'b1, 1'b0);
		expect_run(0, 8, 0, 1, 1, 16'h0005, 2, 0);
		check_frags();
		run_seg(12'd8, 12'd0, 12'd12, 12'd0, 1'b0, 1'b0);
		expect_run(8, 4, 0, 1, 1, 16'h0005, 2, 8);
		check_frags();
		run_seg(12'd8, 12'd0, 12'd12, 12'd0, 1'b0, 1'b1);
		expect_run(8, 4, 0, 1, 1, 16'h0005, 2, 0);
		check_frags();
		reg_read(`REG_STATUS, d);
		`CHK(d, 32'h0000_0004)
		stall = 1'b0;
	endtask

	task automatic test_nomask;
		reg_write(`REG_CTRL, 32'h0);
		run_seg(12'd0, 12'd0, 12'd4, 12'd0, 1'b1, 1'b0);
		expect_run(0, 4, 0, 1, 0, 16'h0005, 2, 0);
		check_frags();
		run_seg(12'd3, 12'd0, 12'd3, 12'd2, 1'b1, 1'b0);
		exp_q.push_back({12'd3, 12'd0, `COV_FULL, 4'hF});
		exp_q.push_back({12'd3, 12'd1, `COV_FULL, 4'hF});
		check_frags();
	endtask

	// 2.75 rounds to 3; 15 clamps to the maximum aliased width
	task automatic test_wide;
		reg_write(`REG_CTRL, 32'h1);
		reg_write(`REG_PATTERN, 32'h0001_0001);
		reg_write(`REG_WIDTH, 32'h0000_002C);
		run_seg(12'd0, 12'd5, 12'd2, 12'd5, 1'b1, 1'b0);
		expect_run(0, 2, 5, 3, 1, 16'h0001, 1, 0);
		check_frags();
		reg_write(`REG_CTRL, 32'h0);
		reg_write(`REG_WIDTH, 32'h0000_00F0);
		run_seg(12'd0, 12'd5, 12'd1, 12'd5, 1'b1, 1'b0);
		expect_run(0, 1, 5, MAX_W, 0, 16'h0001, 1, 0);
		check_frags();
		reg_write(`REG_WIDTH, 32'h0000_0010);
	endtask

	// a centred unit line: the extra edge pixel of the rectangle stays empty
	task automatic test_smooth;
		reg_write(`REG_CTRL, 32'h2);
		run_seg(12'd0, 12'd5, 12'd2, 12'd5, 1'b1, 1'b0);
		expect_run(0, 2, 5, 1, 0, 16'h0000, 1, 0);
		check_frags();
		reg_write(`REG_CTRL, 32'h14);
		run_seg(12'd0, 12'd5, 12'd2, 12'd5, 1'b1, 1'b0);
		expect_run(0, 2, 5, 1, 0, 16'h0000, 1, 0);
		check_frags();
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic complete_run;
		$display("errors %0d, compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// the whole sequence needs well under two thousand cycles
	initial
	begin
		#500000;
		num_errors++;
		complete_run();
	end

	initial
	begin
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		test_reset();
		test_pattern();
		test_stipple();
		test_nomask();
		test_wide();
		test_smooth();
		repeat (2) @(posedge i_clock);
		complete_run();
	end
endmodule
`undef CHK
`default_nettype wire
